// ---- hw/acsc_pkg.sv ----
// Purpose: Shared constants and types for the channel zero configuration block.
// Assumes: 32-bit AXI4-Lite register bus, registers on aligned words.
// Notes:   Config field positions, codes, offsets and reset values live here; status and enable bit positions are set in acsc_top.
package acsc_pkg;

    // Bus geometry.
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam int          CFG_W         = 16;

    // Register byte offsets.
    localparam logic [7:0]  OFF_CH0_CFG   = 8'h10;
    localparam logic [7:0]  OFF_CH_EN     = 8'h14;
    localparam logic [7:0]  OFF_STATUS    = 8'h18;

    // Channel zero configuration layout and reset value.
    localparam logic [15:0] CH0_CFG_RESET = 16'h8001;
    localparam logic [15:0] CFG_WR_MASK   = 16'hB3FF;
    localparam int          CFG_EN_BIT    = 15;
    localparam int          CFG_SETUP_LO  = 12;
    localparam int          CFG_POS_LO    = 5;
    localparam int          CFG_NEG_LO    = 0;
    localparam int          SEL_W         = 5;
    localparam int          SETUP_W       = 2;

    // Channel and setup counts.
    localparam int          NUM_CH        = 4;
    localparam int          NUM_SETUP     = 4;
    localparam logic [2:0]  OTHER_EN_RESET = 3'h0;

    // Input selector codes.
    localparam logic [4:0]  SEL_AIN0      = 5'h00;
    localparam logic [4:0]  SEL_AIN4      = 5'h04;
    localparam logic [4:0]  SEL_TEMP_P    = 5'h11;
    localparam logic [4:0]  SEL_TEMP_N    = 5'h12;
    localparam logic [4:0]  SEL_SUPPLY_P  = 5'h13;
    localparam logic [4:0]  SEL_SUPPLY_N  = 5'h14;
    localparam logic [4:0]  SEL_REF_P     = 5'h15;
    localparam logic [4:0]  SEL_REF_N     = 5'h16;

    // Bus responses.
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    // Sequencer states.
    typedef enum logic [2:0] {
        SEQ_IDLE   = 3'b001,
        SEQ_SINGLE = 3'b010,
        SEQ_SCAN   = 3'b100
    } acsc_seq_e;

endpackage

// ---- hw/acsc_route_decode.sv ----
// Purpose: Classifies selector codes and expands the setup index to a one-hot group select.
// Assumes: Purely combinational; the caller registers the results.
// Notes:   Codes outside the table are flagged as reserved.
`timescale 1ns/1ps
`default_nettype none
module acsc_route_decode
    import acsc_pkg::*;
(
    // Configuration fields
    input  wire logic [SEL_W-1:0]     posSel,
    input  wire logic [SEL_W-1:0]     negSel,
    input  wire logic [SETUP_W-1:0]   setupSel,
    // Decoded results
    output logic                      posListed,
    output logic                      negListed,
    output logic [NUM_SETUP-1:0]      setupOneHot
);

    function automatic logic codeListed(input logic [SEL_W-1:0] code);
        codeListed = (code <= SEL_AIN4) || ((code >= SEL_TEMP_P) && (code <= SEL_REF_N)); // RQ11
    endfunction

    assign posListed = codeListed(posSel); // RQ8
    assign negListed = codeListed(negSel); // RQ10

    // Each setup index enables its whole register group at once.
    genvar g;
    generate
        for (g = 0; g < NUM_SETUP; g++) begin : gSetup
            assign setupOneHot[g] = (setupSel == SETUP_W'(g)); // RQ5
        end
    endgenerate

endmodule
`default_nettype wire

// ---- hw/acsc_sequencer.sv ----
// Purpose: Steps through enabled channels, one per finished conversion.
// Assumes: convDone is a one-cycle pulse from logic on mclk.
// Notes:   Order is ascending with wrap to the lowest enabled channel.
`timescale 1ns/1ps
`default_nettype none
module acsc_sequencer
    import acsc_pkg::*;
#(
    parameter int CH = NUM_CH
)(
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  srst,
    // Control
    input  wire logic [CH-1:0]         chEnable,
    input  wire logic                  convDone,
    // Status
    output logic [$clog2(CH)-1:0]      activeChannel,
    output logic                       scanning,
    output logic                       anyEnabled
);

    generate
        if (CH < 2) begin : gChCheck
            $error("acsc_sequencer needs at least two channels");
        end
    endgenerate

    typedef struct packed {
        acsc_seq_e              mode;
        logic [$clog2(CH)-1:0]  cur;
    } acsc_seqst_s;

    acsc_seqst_s st;
    acsc_seqst_s next_st;

    // Lowest enabled channel above the current one, else the lowest enabled overall.
    function automatic logic [$clog2(CH)-1:0] pickNext(input logic [CH-1:0] en,
                                                       input logic [$clog2(CH)-1:0] cur);
        logic [$clog2(CH)-1:0] above;
        logic [$clog2(CH)-1:0] lowest;
        logic                  foundAbove;
        logic                  foundLow;
        above = '0;
        lowest = '0;
        foundAbove = 1'b0;
        foundLow = 1'b0;
        for (int i = 0; i < CH; i++) begin
            if (en[i] && !foundLow) begin
                lowest = i[$clog2(CH)-1:0];
                foundLow = 1'b1;
            end
            if (en[i] && !foundAbove && (i > int'(cur))) begin
                above = i[$clog2(CH)-1:0];
                foundAbove = 1'b1;
            end
        end
        pickNext = foundAbove ? above : lowest; // RQ11
    endfunction

    logic multi;
    assign multi = ($countones(chEnable) >= 2);

    always_comb begin
        next_st = st;
        if (chEnable == '0) begin
            next_st.mode = SEQ_IDLE;
        end else if (!chEnable[st.cur]) begin
            next_st.cur = pickNext(chEnable, st.cur);
            next_st.mode = multi ? SEQ_SCAN : SEQ_SINGLE;
        end else begin
            case (st.mode)
                SEQ_IDLE: begin
                    next_st.mode = multi ? SEQ_SCAN : SEQ_SINGLE;
                end
                SEQ_SINGLE: begin
                    if (multi) begin
                        next_st.mode = SEQ_SCAN;
                    end
                end
                SEQ_SCAN: begin
                    if (convDone) begin
                        next_st.cur = pickNext(chEnable, st.cur); // RQ3
                    end
                    if (!multi) begin
                        next_st.mode = SEQ_SINGLE;
                    end
                end
                default: begin
                    next_st.mode = SEQ_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            st <= '{mode: SEQ_IDLE, cur: '0};
        end else begin
            st <= next_st;
        end
    end

    assign activeChannel = st.cur;
    assign scanning      = (st.mode == SEQ_SCAN);
    assign anyEnabled    = (st.mode != SEQ_IDLE);

endmodule
`default_nettype wire

// ---- hw/acsc_top.sv ----
// Purpose: Channel zero configuration register with an AXI4-Lite slave and channel routing.
// Assumes: Single clock mclk at 200 MHz, synchronous active-high reset srst.
// Notes:   Routing outputs follow channel zero only while it is the active channel.
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RQ1: 16-bit config at 0x10, resets 0x8001.
// RQ2: Bit 15 enables channel zero, default on.
// RQ3: Two or more enables scan channels automatically.
// RQ4: Bits 13:12 pick one of four setups.
// RQ5: Setup choice applies its four-register group.
// RQ6: Host writes same selector for shared setup.
// RQ7: Reserved bits 14, 11:10 read zero.
// RQ8: Bits 9:5 route the positive converter input.
// RQ9: Host enables buffers before supply monitor codes.
// RQ10: Bits 4:0 route negative input, reset one.
// RQ11: Ascending scan with wrap; unlisted codes reserved.
module acsc_top
    import acsc_pkg::*;
(
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  srst,
    // AXI4-Lite write address
    input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [DATA_W-1:0]     s_axi_wdata,
    input  wire logic [DATA_W/8-1:0]   s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [ADDR_W-1:0]     s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    // AXI4-Lite read data
    output logic [DATA_W-1:0]          s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // Converter events
    input  wire logic                  convDone,
    // Converter routing
    output logic [NUM_CH-1:0]          channelEnable,
    output logic [1:0]                 activeChannel,
    output logic                       scanActive,
    output logic                       channelZeroActive,
    output logic [SEL_W-1:0]           positiveInputSelect,
    output logic [SEL_W-1:0]           negativeInputSelect,
    output logic [SETUP_W-1:0]         setupSelect,
    output logic [NUM_SETUP-1:0]       setupGroupSelect,
    output logic                       routeReserved
);

    typedef struct packed {
        logic [CFG_W-1:0]     cfg;
        logic [2:0]           otherEn;
        logic                 awHeld;
        logic [ADDR_W-1:0]    awAddr;
        logic                 wHeld;
        logic [DATA_W-1:0]    wData;
        logic [DATA_W/8-1:0]  wStrb;
        logic                 awready;
        logic                 wready;
        logic                 bvalid;
        logic [1:0]           bresp;
        logic                 arready;
        logic                 rvalid;
        logic [DATA_W-1:0]    rdata;
        logic [1:0]           rresp;
        logic [NUM_CH-1:0]    chEn;
        logic [1:0]           actCh;
        logic                 scan;
        logic                 ch0Act;
        logic [SEL_W-1:0]     pos;
        logic [SEL_W-1:0]     neg;
        logic [SETUP_W-1:0]   setup;
        logic [NUM_SETUP-1:0] group;
        logic                 rsvd;
    } acsc_state_s;

    acsc_state_s st;
    acsc_state_s next_st;

    // The routing and status layout assume four channels and a 16-bit register.
    generate
        if (NUM_CH != 4 || CFG_W != 16 || SETUP_W != 2) begin : gGeomCheck
            $error("acsc_top needs four channels, two setup bits and a 16-bit register");
        end
    endgenerate

    // Configuration fields.
    logic                 ch0Enable;
    logic [SETUP_W-1:0]   setupField;
    logic [SEL_W-1:0]     posField;
    logic [SEL_W-1:0]     negField;
    logic [NUM_CH-1:0]    enableMask;

    assign ch0Enable  = st.cfg[CFG_EN_BIT]; // RQ2
    assign setupField = st.cfg[CFG_SETUP_LO +: SETUP_W]; // RQ4
    assign posField   = st.cfg[CFG_POS_LO +: SEL_W]; // RQ8
    assign negField   = st.cfg[CFG_NEG_LO +: SEL_W]; // RQ10
    assign enableMask = {st.otherEn, ch0Enable};

    // Sequencer and decode.
    logic [1:0]           seqChannel;
    logic                 seqScanning;
    logic                 seqAny;
    logic                 posListed;
    logic                 negListed;
    logic [NUM_SETUP-1:0] setupOneHot;

    acsc_sequencer #(
        .CH            (NUM_CH)
    ) uSeq (
        .mclk          (mclk),
        .srst          (srst),
        .chEnable      (enableMask),
        .convDone      (convDone),
        .activeChannel (seqChannel),
        .scanning      (seqScanning),
        .anyEnabled    (seqAny)
    );

    acsc_route_decode uDec (
        .posSel        (posField),
        .negSel        (negField),
        .setupSel      (setupField),
        .posListed     (posListed),
        .negListed     (negListed),
        .setupOneHot   (setupOneHot)
    );

    // Merges a write into a 16-bit field by byte lane, keeping reserved bits at zero.
    // Lanes two and three carry nothing for this register.
    function automatic logic [CFG_W-1:0] mergeCfg(input logic [CFG_W-1:0]    old,
                                                  input logic [DATA_W-1:0]   data,
                                                  input logic [DATA_W/8-1:0] strb);
        logic [CFG_W-1:0] res;
        res = old;
        if (strb[0]) begin
            res[7:0] = data[7:0];
        end
        if (strb[1]) begin
            res[15:8] = data[15:8];
        end
        mergeCfg = res & CFG_WR_MASK; // RQ7
    endfunction

    // Read mux; unmapped addresses answer with an error and zero data.
    logic [DATA_W-1:0] rdValue;
    logic              rdHit;

    always_comb begin
        rdValue = '0;
        rdHit   = 1'b1;
        case (s_axi_araddr)
            OFF_CH0_CFG: begin
                rdValue[CFG_W-1:0] = st.cfg & CFG_WR_MASK; // RQ7
            end
            OFF_CH_EN: begin
                rdValue[2:0] = st.otherEn;
            end
            OFF_STATUS: begin
                rdValue[1:0]  = st.actCh;
                rdValue[2]    = st.scan;
                rdValue[3]    = st.ch0Act;
                rdValue[4]    = ~posListed;
                rdValue[5]    = ~negListed;
                rdValue[6]    = seqAny;
                rdValue[11:8] = st.chEn;
            end
            default: begin
                rdHit = 1'b0;
            end
        endcase
    end

    logic aw_fire;
    logic w_fire;
    logic ar_fire;

    assign aw_fire = s_axi_awvalid && st.awready;
    assign w_fire  = s_axi_wvalid && st.wready;
    assign ar_fire = s_axi_arvalid && st.arready;

    always_comb begin
        next_st = st;

        // Write address and data are captured independently.
        if (aw_fire) begin
            next_st.awHeld = 1'b1;
            next_st.awAddr = s_axi_awaddr;
        end
        if (w_fire) begin
            next_st.wHeld = 1'b1;
            next_st.wData = s_axi_wdata;
            next_st.wStrb = s_axi_wstrb;
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end

        // Once both halves are held, the write is performed and answered.
        if (st.awHeld && st.wHeld && !st.bvalid) begin
            next_st.awHeld = 1'b0;
            next_st.wHeld  = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp  = RESP_OKAY;
            case (st.awAddr)
                OFF_CH0_CFG: begin
                    next_st.cfg = mergeCfg(st.cfg, st.wData, st.wStrb); // RQ1
                end
                OFF_CH_EN: begin
                    if (st.wStrb[0]) begin
                        next_st.otherEn = st.wData[2:0];
                    end
                end
                OFF_STATUS: begin
                    next_st.bresp = RESP_OKAY;
                end
                default: begin
                    next_st.bresp = RESP_SLVERR;
                end
            endcase
        end

        // Readiness follows the next state, so a new request waits for the response.
        next_st.awready = !next_st.awHeld && !next_st.bvalid;
        next_st.wready  = !next_st.wHeld && !next_st.bvalid;

        // Read channel.
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (ar_fire) begin
            next_st.rvalid = 1'b1;
            next_st.rdata  = rdValue;
            next_st.rresp  = rdHit ? RESP_OKAY : RESP_SLVERR;
        end
        // A read address waits while read data stands, so one read is in flight.
        next_st.arready = !next_st.rvalid;

        // Routing follows channel zero while the sequencer sits on it.
        next_st.chEn   = enableMask;
        next_st.actCh  = seqChannel;
        next_st.scan   = seqScanning; // RQ3
        next_st.ch0Act = seqAny && (seqChannel == 2'h0) && ch0Enable; // RQ2
        if (next_st.ch0Act) begin
            next_st.pos   = posField; // RQ8
            next_st.neg   = negField; // RQ10
            next_st.setup = setupField; // RQ4
            next_st.group = setupOneHot; // RQ5
            // Unlisted codes are still routed; the flag only marks them as reserved.
            next_st.rsvd  = !posListed || !negListed; // RQ11
        end else begin
            next_st.group = '0;
            next_st.rsvd  = 1'b0;
        end
    end

    // Reset loads only constants, so routing starts on pin zero and pin one.
    always_ff @(posedge mclk) begin
        if (srst) begin
            st         <= '0;
            st.cfg     <= CH0_CFG_RESET; // RQ1
            st.otherEn <= OTHER_EN_RESET;
            st.pos     <= CH0_CFG_RESET[CFG_POS_LO +: SEL_W];
            st.neg     <= CH0_CFG_RESET[CFG_NEG_LO +: SEL_W];
            st.bresp   <= RESP_OKAY;
            st.rresp   <= RESP_OKAY;
        end else begin
            st <= next_st;
        end
    end

    // Every output is a field of the registered state.
    assign s_axi_awready       = st.awready;
    assign s_axi_wready        = st.wready;
    assign s_axi_bresp         = st.bresp;
    assign s_axi_bvalid        = st.bvalid;
    assign s_axi_arready       = st.arready;
    assign s_axi_rdata         = st.rdata;
    assign s_axi_rresp         = st.rresp;
    assign s_axi_rvalid        = st.rvalid;
    assign channelEnable       = st.chEn;
    assign activeChannel       = st.actCh;
    assign scanActive          = st.scan;
    assign channelZeroActive   = st.ch0Act;
    assign positiveInputSelect = st.pos;
    assign negativeInputSelect = st.neg;
    assign setupSelect         = st.setup;
    assign setupGroupSelect    = st.group;
    assign routeReserved       = st.rsvd;

endmodule
`default_nettype wire

// ---- bench/acsc_top_checker.sv ----
// Purpose: Concurrent checks on the ports of the channel zero configuration block.
// Assumes: Single clock mclk, synchronous active-high reset srst.
// Notes:   Bound to acsc_top after the module.
`timescale 1ns/1ps
`default_nettype none
module acsc_top_checker
    import acsc_pkg::*;
(
    // Clock and reset
    input wire logic              mclk,
    input wire logic              srst,
    // Bus handshakes
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [DATA_W-1:0] s_axi_rdata,
    input wire logic [1:0]        s_axi_rresp,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    // Routing
    input wire logic              convDone,
    input wire logic [1:0]        activeChannel,
    input wire logic              scanActive,
    input wire logic              channelZeroActive,
    input wire logic [SEL_W-1:0]  positiveInputSelect,
    input wire logic [SEL_W-1:0]  negativeInputSelect,
    input wire logic [1:0]        setupSelect,
    input wire logic [3:0]        setupGroupSelect,
    input wire logic              routeReserved
);
    logic [ADDR_W-1:0] readAddr;

    always_ff @(posedge mclk) begin
        if (srst) readAddr <= '0;
        else if (s_axi_arvalid && s_axi_arready) readAddr <= s_axi_araddr;
    end

    function automatic logic listed(input logic [4:0] c);
        return (c <= SEL_AIN4) || (c >= SEL_TEMP_P && c <= SEL_REF_N);
    endfunction

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    AST_CFG_RESERVED: assert property (s_axi_rvalid && readAddr == OFF_CH0_CFG |->
        s_axi_rdata[31:16] == 16'h0000 && !s_axi_rdata[14] && s_axi_rdata[11:10] == 2'h0)
        else $error("Reserved config bits read nonzero.");
    AST_UNMAPPED: assert property (s_axi_rvalid && readAddr > OFF_STATUS |->
        s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
        else $error("Unmapped read not refused.");
    AST_SETUP_GROUP: assert property (setupGroupSelect != 4'h0 |->
        setupGroupSelect == (4'h1 << setupSelect) && channelZeroActive)
        else $error("Setup group does not match selector.");
    AST_ADVANCE: assert property (scanActive && convDone |-> ##[1:4] $changed(activeChannel))
        else $error("Scan did not advance.");
    AST_ZERO_ACTIVE: assert property (channelZeroActive |-> activeChannel == 2'h0)
        else $error("Channel zero active on other index.");
    AST_RES_FLAG: assert property (routeReserved |->
        !(listed(positiveInputSelect) && listed(negativeInputSelect)))
        else $error("Reserved flag on listed codes.");
    AST_RESET_ROUTE: assert property ($fell(srst) |->
        negativeInputSelect == 5'h01 && positiveInputSelect == 5'h00 && setupSelect == 2'h0)
        else $error("Routing reset values wrong.");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("Write response dropped early.");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("Read data dropped early.");
    AST_B_AFTER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid)
        else $error("No write response after address and data.");

    COV_SCAN: cover property (scanActive && convDone);
    COV_RES: cover property (routeReserved);
    COV_ERR: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule

bind acsc_top acsc_top_checker u_chk (.mclk, .srst, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .convDone, .activeChannel, .scanActive, .channelZeroActive, .positiveInputSelect,
    .negativeInputSelect, .setupSelect, .setupGroupSelect, .routeReserved);
`default_nettype wire

// ---- bench/test_adc_channel_select_config.sv ----
// Purpose: Register and routing tests of the channel zero configuration block.
// Assumes: AXI4-Lite master tasks handshake at negedge-sampled readiness.
// Notes:   Routing outputs are checked after a short settle.
`timescale 1ns/1ps
`default_nettype none
module test_adc_channel_select_config;
    import acsc_pkg::*;
    logic        mclk, srst, convDone;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb, channelEnable, setupGroupSelect;
    logic [1:0]  s_axi_bresp, s_axi_rresp, activeChannel, setupSelect, rs;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        scanActive, channelZeroActive, routeReserved;
    logic [4:0]  positiveInputSelect, negativeInputSelect;
    logic [4:0]  codes [11] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h11, 5'h12, 5'h13, 5'h14,
                                5'h15, 5'h16};
    int          errors = 0;
    int          checked = 0;

    acsc_top dut (.mclk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .convDone, .channelEnable, .activeChannel, .scanActive,
        .channelZeroActive, .positiveInputSelect, .negativeInputSelect, .setupSelect,
        .setupGroupSelect, .routeReserved);

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        logic ah, wh, bh;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (1) begin
            @(negedge mclk);
            ah = s_axi_awready;
            wh = s_axi_wready;
            bh = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge mclk);
            if (ah) s_axi_awvalid <= 1'b0;
            if (wh) s_axi_wvalid <= 1'b0;
            if (bh) break;
        end
    endtask

    task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        logic ah, rv;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (1) begin
            @(negedge mclk);
            ah = s_axi_arready;
            rv = s_axi_rvalid;
            d = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge mclk);
            if (ah) s_axi_arvalid <= 1'b0;
            if (rv) break;
        end
    endtask

    task automatic pulse();
        convDone <= 1'b1;
        @(posedge mclk);
        convDone <= 1'b0;
        settle(6);
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        give_verdict();
    end

    initial begin
        {srst, convDone} = 2'b10;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        settle(10);
        srst <= 1'b0;
        settle(6);
        rdr(OFF_CH0_CFG, rd, rs);
        chk(rd, 32'h0000_8001);
        chk(channelEnable, 4'h1);
        chk({setupSelect, setupGroupSelect}, 6'h01);
        chk({positiveInputSelect, negativeInputSelect}, 10'h001);
        chk({channelZeroActive, scanActive, routeReserved}, 3'h4);
        $display("test reset done");
        wr(OFF_CH0_CFG, 32'hFFFF_FFFF, rs);
        rdr(OFF_CH0_CFG, rd, rs);
        chk(rd, 32'h0000_B3FF);
        settle(6);
        chk({routeReserved, setupGroupSelect}, 5'h18);
        $display("test reserved done");
        for (int s = 0; s < 4; s++) begin
            wr(OFF_CH0_CFG, {16'h0000, 2'b10, s[1:0], 12'h001}, rs);
            settle(6);
            chk(setupSelect, s);
            chk(setupGroupSelect, 4'h1 << s);
        end
        $display("test setups done");
        foreach (codes[i]) begin
            wr(OFF_CH0_CFG, {16'h0000, 6'b100000, codes[i], codes[i]}, rs);
            settle(6);
            chk({positiveInputSelect, negativeInputSelect}, {codes[i], codes[i]});
            chk(routeReserved, 1'b0);
        end
        $display("test codes done");
        wr(8'h20, 32'h0000_0000, rs);
        chk(rs, RESP_SLVERR);
        rdr(8'h20, rd, rs);
        chk({rd, rs}, {32'h0000_0000, RESP_SLVERR});
        rdr(OFF_CH0_CFG, rd, rs);
        chk(rd, 32'h0000_82D6);
        $display("test unmapped done");
        wr(OFF_CH_EN, 32'h0000_0005, rs);
        settle(6);
        chk({scanActive, channelEnable, activeChannel}, 7'h6C);
        pulse();
        chk({activeChannel, channelZeroActive}, 3'h2);
        pulse();
        chk(activeChannel, 2'h3);
        pulse();
        chk({activeChannel, channelZeroActive}, 3'h1);
        wr(OFF_CH_EN, 32'h0000_0000, rs);
        settle(6);
        chk(scanActive, 1'b0);
        $display("test scan done");
        wr(OFF_CH0_CFG, 32'h0000_0001, rs);
        settle(6);
        chk({channelEnable, channelZeroActive}, 5'h00);
        rdr(OFF_CH0_CFG, rd, rs);
        chk(rd, 32'h0000_0001);
        $display("test disable done");
        give_verdict();
    end
endmodule
`default_nettype wire
